// file: oes_pkg.sv
// Purpose: shared constants and types for the operator element state sync block
// Assumes: 100 MHz core clock
// Notes:   all field positions, codes and timing counts live here
package oes_pkg;
    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ           = 100;
    localparam int DEBOUNCE_US       = 1000;
    localparam int DEBOUNCE_CYC      = DEBOUNCE_US * CLK_MHZ;
    localparam int WHEEL_FILT_US     = 20;
    localparam int WHEEL_FILT_CYC    = WHEEL_FILT_US * CLK_MHZ;
    localparam int ALIVE_MS          = 100;
    localparam int ALIVE_CYC         = ALIVE_MS * 1000 * CLK_MHZ;
    localparam int SLOW_HALF_MS      = 500;
    localparam int SLOW_HALF_CYC     = SLOW_HALF_MS * 1000 * CLK_MHZ;
    localparam int RAPID_HALF_MS     = 125;
    localparam int RAPID_HALF_CYC    = RAPID_HALF_MS * 1000 * CLK_MHZ;
    localparam int WHEEL_PULSES_REV  = 50;
    localparam int WHEEL_MAX_PPS     = 200;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int NET_W  = 16;
    localparam int CNT_W  = 8;
    localparam int TRIG_W = 16;

    // ----------------------------------------------------------------
    // register map of the plain port
    // ----------------------------------------------------------------
    localparam logic [3:0] ADR_STATUS    = 4'h0;
    localparam logic [3:0] ADR_KEY       = 4'h1;
    localparam logic [3:0] ADR_NET       = 4'h2;
    localparam logic [3:0] ADR_FWD_CNT   = 4'h3;
    localparam logic [3:0] ADR_BWD_CNT   = 4'h4;
    localparam logic [3:0] ADR_LAMP      = 4'h5;
    localparam logic [3:0] ADR_TRIG      = 4'h6;
    localparam logic [3:0] ADR_CTRL_COPY = 4'h7;
    localparam logic [3:0] ADR_CFG       = 4'h8;
    localparam logic [3:0] ADR_ALIVE     = 4'h9;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int BIT_BUTTON      = 0;
    localparam int BIT_CFG_SIGNED  = 0;
    localparam int BIT_CFG_KEYBOOL = 1;
    localparam int BIT_CFG_WIDE    = 2;
    localparam int BIT_PROTECT     = 0;

    // ----------------------------------------------------------------
    // codes
    // ----------------------------------------------------------------
    localparam logic [1:0] LAMP_OFF   = 2'h0;
    localparam logic [1:0] LAMP_RAPID = 2'h1;
    localparam logic [1:0] LAMP_SLOW  = 2'h2;
    localparam logic [1:0] LAMP_ON    = 2'h3;
    localparam logic [1:0] KEY_CENTRE = 2'h0;
    localparam logic [1:0] KEY_CW     = 2'h2;
    localparam logic [1:0] KEY_CCW    = 2'h1;
    localparam logic [2:0] CFG_RESET  = 3'h4;

    // ----------------------------------------------------------------
    // element state carrier
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [NET_W-1:0] net;
        logic [1:0]       key;
        logic             button;
    } oes_elem_t;

    typedef enum logic [2:0] {
        SYNC_IDLE = 3'b001,
        SYNC_LINK = 3'b010,
        SYNC_RUN  = 3'b100
    } oes_sync_t;
endpackage : oes_pkg

// file: oes_debounce.sv
// Purpose: two-flop synchroniser followed by a stable-time filter
// Assumes: single clock, asynchronous active-low reset
// Notes:   output changes only after the input holds for CYC cycles
`timescale 1ns/1ps
module oes_debounce #(
    parameter int         CYC  = 16,
    parameter logic       INIT = 1'b0
) (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_arst_n,
    // raw level in, clean level out
    input  wire logic i_raw,
    output logic      o_clean
);
    localparam int CW = $clog2(CYC + 1);

    logic          meta_q;
    logic          sync_q;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          clean_q;
    logic          differs;
    logic          done;

    // ----------------------------------------------------------------
    // filter decode
    // ----------------------------------------------------------------
    assign differs = sync_q != clean_q;
    assign done    = cnt_q == CW'(CYC - 1);
    assign cnt_d   = (differs && !done) ? cnt_q + 1'b1 : '0;
    assign o_clean = clean_q;

    // synchroniser, counter and filtered level
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta_q  <= INIT;
            sync_q  <= INIT;
            cnt_q   <= '0;
            clean_q <= INIT;
        end else begin
            meta_q  <= i_raw;
            sync_q  <= meta_q;
            cnt_q   <= cnt_d;
            clean_q <= (differs && done) ? sync_q : clean_q;
        end
    end
endmodule : oes_debounce

// file: oes_divider.sv
// Purpose: square wave from a half-period count
// Assumes: single clock
// Notes:   used for the lamp flash rates and the link-alive toggle
`timescale 1ns/1ps
module oes_divider #(
    parameter int HALF = 4
) (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_arst_n,
    // divided output
    output logic      o_wave
);
    localparam int CW = $clog2(HALF + 1);

    logic [CW-1:0] cnt_q;
    logic          wave_q;
    logic          wrap;

    assign wrap   = cnt_q == CW'(HALF - 1);
    assign o_wave = wave_q;

    // half-period counter that flips the wave at each wrap
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_q  <= '0;
            wave_q <= 1'b0;
        end else begin
            cnt_q  <= wrap ? '0 : cnt_q + 1'b1;
            wave_q <= wrap ? !wave_q : wave_q;
        end
    end
endmodule : oes_divider

// file: oes_top.sv
// Purpose: operator element encoding and controller state sync
// Assumes: element pins synchronous to I_CORE_CLK only after internal syncs
// Notes:   controller reaches the block over a plain register port
`timescale 1ns/1ps
module oes_top #(
    parameter int DEBOUNCE_CYC   = oes_pkg::DEBOUNCE_CYC,
    parameter int WHEEL_FILT_CYC = oes_pkg::WHEEL_FILT_CYC,
    parameter int ALIVE_CYC      = oes_pkg::ALIVE_CYC,
    parameter int SLOW_HALF_CYC  = oes_pkg::SLOW_HALF_CYC,
    parameter int RAPID_HALF_CYC = oes_pkg::RAPID_HALF_CYC
) (
    // clock and reset
    input  wire logic                    I_CORE_CLK,
    input  wire logic                    I_ARST_N,
    // operator element pins
    input  wire logic                    I_BUTTON_PRESSED,
    input  wire logic                    I_KEY_CW,
    input  wire logic                    I_KEY_CCW,
    input  wire logic                    I_WHEEL_FWD,
    input  wire logic                    I_WHEEL_BWD,
    // link state and stale controller value
    input  wire logic                    I_LINK_UP,
    input  wire oes_pkg::oes_elem_t      I_STALE_VALUE,
    // register port
    input  wire logic [3:0]              I_ADDR,
    input  wire logic [31:0]             I_WDATA,
    input  wire logic                    I_WR,
    input  wire logic                    I_RD,
    output logic [31:0]                  O_RDATA,
    // element outputs
    output logic                         O_LAMP,
    output logic                         O_PROTECT_LOCK,
    output oes_pkg::oes_elem_t           O_CTRL_COPY,
    output logic                         O_CTRL_SEND
);
    // ----------------------------------------------------------------
    // input conditioning
    // ----------------------------------------------------------------
    logic btn_pressed;
    logic key_cw;
    logic key_ccw;
    logic whl_fwd;
    logic whl_bwd;
    logic whl_fwd_q;
    logic whl_bwd_q;

    // debounced element levels
    oes_debounce #(.CYC(DEBOUNCE_CYC), .INIT(1'b0)) u_db_btn (
        .i_clk(I_CORE_CLK), .i_arst_n(I_ARST_N),
        .i_raw(I_BUTTON_PRESSED), .o_clean(btn_pressed));
    oes_debounce #(.CYC(DEBOUNCE_CYC), .INIT(1'b0)) u_db_cw (
        .i_clk(I_CORE_CLK), .i_arst_n(I_ARST_N),
        .i_raw(I_KEY_CW), .o_clean(key_cw));
    oes_debounce #(.CYC(DEBOUNCE_CYC), .INIT(1'b0)) u_db_ccw (
        .i_clk(I_CORE_CLK), .i_arst_n(I_ARST_N),
        .i_raw(I_KEY_CCW), .o_clean(key_ccw));
    // short filter: 200 pulses/s leaves 2.5 ms per level, far above it
    oes_debounce #(.CYC(WHEEL_FILT_CYC), .INIT(1'b0)) u_db_fwd (
        .i_clk(I_CORE_CLK), .i_arst_n(I_ARST_N),
        .i_raw(I_WHEEL_FWD), .o_clean(whl_fwd));
    oes_debounce #(.CYC(WHEEL_FILT_CYC), .INIT(1'b0)) u_db_bwd (
        .i_clk(I_CORE_CLK), .i_arst_n(I_ARST_N),
        .i_raw(I_WHEEL_BWD), .o_clean(whl_bwd));

    // ----------------------------------------------------------------
    // wheel pulse detect and counts
    // ----------------------------------------------------------------
    logic                      fwd_pulse;
    logic                      bwd_pulse;
    logic [oes_pkg::CNT_W-1:0] fwd_cnt_q;
    logic [oes_pkg::CNT_W-1:0] bwd_cnt_q;
    logic [oes_pkg::NET_W-1:0] net_q;
    logic [oes_pkg::NET_W-1:0] net_step;
    logic [oes_pkg::NET_W-1:0] net_d;
    logic [2:0]                cfg_q;
    logic                      cfg_signed;
    logic                      cfg_wide;
    logic                      cfg_keybool;

    assign cfg_signed  = cfg_q[oes_pkg::BIT_CFG_SIGNED];
    assign cfg_keybool = cfg_q[oes_pkg::BIT_CFG_KEYBOOL];
    assign cfg_wide    = cfg_q[oes_pkg::BIT_CFG_WIDE];

    // each rising edge is one of the 50 detents per turn
    assign fwd_pulse = whl_fwd && !whl_fwd_q;
    assign bwd_pulse = whl_bwd && !whl_bwd_q;

    // simultaneous fwd and bwd cancel; natural modular wrap
    assign net_step = (fwd_pulse && !bwd_pulse) ? net_q + 1'b1 :
                      (bwd_pulse && !fwd_pulse) ? net_q - 1'b1 : net_q;
    // narrow target keeps 8 bits, sign-extended when signed
    assign net_d = cfg_wide ? net_step :
                   {{(oes_pkg::NET_W-oes_pkg::CNT_W){cfg_signed &
                      net_step[oes_pkg::CNT_W-1]}},
                    net_step[oes_pkg::CNT_W-1:0]};

    // edge history, wheel direction counts and net value
    // the 8-bit counts only wrap; a slow reader loses 256 detents per missed wrap
    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            whl_fwd_q <= 1'b0;
            whl_bwd_q <= 1'b0;
            fwd_cnt_q <= '0;
            bwd_cnt_q <= '0;
            net_q     <= '0;
        end else begin
            whl_fwd_q <= whl_fwd;
            whl_bwd_q <= whl_bwd;
            fwd_cnt_q <= fwd_pulse ? fwd_cnt_q + 1'b1 : fwd_cnt_q;
            bwd_cnt_q <= bwd_pulse ? bwd_cnt_q + 1'b1 : bwd_cnt_q;
            net_q     <= net_d;
        end
    end

    // ----------------------------------------------------------------
    // local element status
    // ----------------------------------------------------------------
    oes_pkg::oes_elem_t local_st;
    logic [1:0]         key_code;
    logic [1:0]         key_field;
    logic               lock_d;

    // key code: cw and ccw both asserted is treated as centre
    assign key_code = (key_cw && !key_ccw)  ? oes_pkg::KEY_CW  :
                      (key_ccw && !key_cw)  ? oes_pkg::KEY_CCW :
                                              oes_pkg::KEY_CENTRE;
    assign key_field = cfg_keybool ? {1'b0, key_code != oes_pkg::KEY_CENTRE}
                                   : key_code;
    assign lock_d         = key_code != oes_pkg::KEY_CENTRE;

    // status follows the element at once
    assign local_st.button = !btn_pressed;
    assign local_st.key    = key_field;
    assign local_st.net    = net_q;

    // ----------------------------------------------------------------
    // controller-side copy and resync
    // ----------------------------------------------------------------
    oes_pkg::oes_sync_t         sync_q;
    oes_pkg::oes_elem_t         prev_q;
    oes_pkg::oes_elem_t         copy_q;
    logic [oes_pkg::TRIG_W-1:0] trig_q;
    logic                       trig_changed_q;
    logic                       send_q;
    logic                       link_q;
    logic                       link_rise;
    logic                       local_changed;
    logic                       wr_trig;
    logic                       trig_diff;

    assign link_rise     = I_LINK_UP && !link_q;
    assign local_changed = local_st != prev_q;
    assign wr_trig       = I_WR && (I_ADDR == oes_pkg::ADR_TRIG);
    assign trig_diff     = wr_trig && (I_WDATA[oes_pkg::TRIG_W-1:0] != trig_q);
    assign O_CTRL_COPY   = copy_q;
    assign O_CTRL_SEND   = send_q;

    // link state machine and copy-on-change action
    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            sync_q         <= oes_pkg::SYNC_IDLE;
            prev_q         <= '0;
            copy_q         <= '0;
            trig_q         <= '0;
            trig_changed_q <= 1'b0;
            send_q         <= 1'b0;
            link_q         <= 1'b0;
        end else begin
            link_q         <= I_LINK_UP;
            prev_q         <= local_st;
            trig_q         <= wr_trig ? I_WDATA[oes_pkg::TRIG_W-1:0] : trig_q;
            trig_changed_q <= trig_diff;
            send_q         <= 1'b0;
            case (sync_q)
                oes_pkg::SYNC_IDLE: begin
                    if (link_rise) begin
                        copy_q <= I_STALE_VALUE;
                        sync_q <= oes_pkg::SYNC_LINK;
                    end
                end
                oes_pkg::SYNC_LINK: begin
                    // controller's resync write or a local change is awaited
                    if (!I_LINK_UP) begin
                        sync_q <= oes_pkg::SYNC_IDLE;
                    end else if (trig_changed_q || local_changed) begin
                        copy_q <= local_st;
                        send_q <= 1'b1;
                        sync_q <= oes_pkg::SYNC_RUN;
                    end
                end
                oes_pkg::SYNC_RUN: begin
                    if (!I_LINK_UP) begin
                        sync_q <= oes_pkg::SYNC_IDLE;
                    end else if (trig_changed_q || local_changed) begin
                        copy_q <= local_st;
                        send_q <= 1'b1;
                    end
                end
                default: begin
                    sync_q <= oes_pkg::SYNC_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // lamp and link-alive
    // ----------------------------------------------------------------
    logic [1:0] lamp_state_field_q;
    logic       slow_wave;
    logic       rapid_wave;
    logic       alive_bit;
    logic       lamp_d;
    logic       lamp_q;
    logic       lock_q;

    oes_divider #(.HALF(SLOW_HALF_CYC)) u_div_slow (
        .i_clk(I_CORE_CLK), .i_arst_n(I_ARST_N), .o_wave(slow_wave));
    oes_divider #(.HALF(RAPID_HALF_CYC)) u_div_rapid (
        .i_clk(I_CORE_CLK), .i_arst_n(I_ARST_N), .o_wave(rapid_wave));
    oes_divider #(.HALF(ALIVE_CYC)) u_div_alive (
        .i_clk(I_CORE_CLK), .i_arst_n(I_ARST_N), .o_wave(alive_bit));

    // lamp shows only what the controller wrote
    // a lamp write reaches the pin two edges later
    assign lamp_d = (lamp_state_field_q == oes_pkg::LAMP_ON)    ? 1'b1       :
                    (lamp_state_field_q == oes_pkg::LAMP_SLOW)  ? slow_wave  :
                    (lamp_state_field_q == oes_pkg::LAMP_RAPID) ? rapid_wave :
                                                                  1'b0;

    // pin drives from flip-flops
    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            lamp_q <= 1'b0;
            lock_q <= 1'b0;
        end else begin
            lamp_q <= lamp_d;
            lock_q <= lock_d;
        end
    end
    assign O_LAMP         = lamp_q;
    assign O_PROTECT_LOCK = lock_q;

    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    logic [31:0] rd_mux;
    logic [31:0] rdata_q;

    assign rd_mux =
        (I_ADDR == oes_pkg::ADR_STATUS)    ? 32'({local_st.button})          :
        (I_ADDR == oes_pkg::ADR_KEY)       ? 32'(local_st.key)               :
        (I_ADDR == oes_pkg::ADR_NET)       ? 32'(net_q)                      :
        (I_ADDR == oes_pkg::ADR_FWD_CNT)   ? 32'(fwd_cnt_q)                  :
        (I_ADDR == oes_pkg::ADR_BWD_CNT)   ? 32'(bwd_cnt_q)                  :
        (I_ADDR == oes_pkg::ADR_LAMP)      ? 32'(lamp_state_field_q)         :
        (I_ADDR == oes_pkg::ADR_TRIG)      ? 32'(trig_q)                     :
        (I_ADDR == oes_pkg::ADR_CTRL_COPY) ? 32'(copy_q)                     :
        (I_ADDR == oes_pkg::ADR_CFG)       ? 32'(cfg_q)                      :
        (I_ADDR == oes_pkg::ADR_ALIVE)     ? 32'({alive_bit})                :
                                             32'h0000_0000;
    assign O_RDATA = rdata_q;

    // writable registers and registered read data
    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            lamp_state_field_q <= oes_pkg::LAMP_OFF;
            cfg_q              <= oes_pkg::CFG_RESET;
            rdata_q            <= '0;
        end else begin
            if (I_WR && I_ADDR == oes_pkg::ADR_LAMP) begin
                lamp_state_field_q <= I_WDATA[1:0];
            end
            if (I_WR && I_ADDR == oes_pkg::ADR_CFG) begin
                cfg_q <= I_WDATA[2:0];
            end
            rdata_q <= I_RD ? rd_mux : 32'h0000_0000;
        end
    end
endmodule : oes_top

// file: oes_top_monitor.sv
// Purpose: port-level checks on oes_top
// Assumes: lamp and link inputs held steady between bench steps
// Notes:   bound into every oes_top instance
`timescale 1ns/1ps
module oes_top_monitor (
    // clock and reset
    input  wire logic               I_CORE_CLK,
    input  wire logic               I_ARST_N,
    // inputs watched
    input  wire logic               I_KEY_CW,
    input  wire logic               I_KEY_CCW,
    input  wire logic               I_LINK_UP,
    input  wire oes_pkg::oes_elem_t I_STALE_VALUE,
    input  wire logic [3:0]         I_ADDR,
    input  wire logic [31:0]        I_WDATA,
    input  wire logic               I_WR,
    input  wire logic               I_RD,
    // outputs watched
    input  wire logic [31:0]        O_RDATA,
    input  wire logic               O_LAMP,
    input  wire logic               O_PROTECT_LOCK,
    input  wire oes_pkg::oes_elem_t O_CTRL_COPY,
    input  wire logic               O_CTRL_SEND
);
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_ARST_N);
    // lamp field written from the register port
    sequence s_lamp_wr(logic [1:0] c);
        I_WR && I_ADDR == oes_pkg::ADR_LAMP && I_WDATA[1:0] == c;
    endsequence
    // link comes up after being down
    sequence s_link_rise;
        !I_LINK_UP ##1 I_LINK_UP;
    endsequence
    property p_lamp_off;
        s_lamp_wr(oes_pkg::LAMP_OFF) |=> ##1 !O_LAMP [*4];
    endproperty
    a_lamp_off: assert property (p_lamp_off) else $error("lamp lit while off");
    property p_lamp_on;
        s_lamp_wr(oes_pkg::LAMP_ON) |=> ##1 O_LAMP [*4];
    endproperty
    a_lamp_on: assert property (p_lamp_on) else $error("lamp dark while on");
    property p_lock;
        $rose(O_PROTECT_LOCK) |-> $past(I_KEY_CW ^ I_KEY_CCW, 4);
    endproperty
    a_lock: assert property (p_lock) else $error("lock without end stop");
    property p_no_send;
        !I_LINK_UP [*3] |-> !O_CTRL_SEND;
    endproperty
    a_no_send: assert property (p_no_send) else $error("send while link down");
    property p_send_one;
        O_CTRL_SEND |=> !O_CTRL_SEND;
    endproperty
    a_send_one: assert property (p_send_one) else $error("send over one cycle");
    property p_copy_hold;
        $changed(O_CTRL_COPY) |-> O_CTRL_SEND || ($past(I_LINK_UP) && !$past(I_LINK_UP, 2));
    endproperty
    a_copy_hold: assert property (p_copy_hold) else $error("unasked copy");
    property p_link_copy;
        s_link_rise |=> O_CTRL_COPY == $past(I_STALE_VALUE);
    endproperty
    a_link_copy: assert property (p_link_copy) else $error("stale value not taken");
    property p_rd_copy;
        I_RD && I_ADDR == oes_pkg::ADR_CTRL_COPY |=> O_RDATA == {13'h0, $past(O_CTRL_COPY)};
    endproperty
    a_rd_copy: assert property (p_rd_copy) else $error("copy read mismatch");
    property p_rd_key;
        I_RD && I_ADDR == oes_pkg::ADR_KEY |=> (O_RDATA[1:0] != 2'h0) == O_PROTECT_LOCK;
    endproperty
    a_rd_key: assert property (p_rd_key) else $error("key read vs lock");
endmodule : oes_top_monitor

bind oes_top oes_top_monitor oes_top_monitor_inst (.I_CORE_CLK(I_CORE_CLK),
    .I_ARST_N(I_ARST_N), .I_KEY_CW(I_KEY_CW), .I_KEY_CCW(I_KEY_CCW), .I_LINK_UP(I_LINK_UP),
    .I_STALE_VALUE(I_STALE_VALUE), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
    .I_RD(I_RD), .O_RDATA(O_RDATA), .O_LAMP(O_LAMP), .O_PROTECT_LOCK(O_PROTECT_LOCK),
    .O_CTRL_COPY(O_CTRL_COPY), .O_CTRL_SEND(O_CTRL_SEND));

// file: oes_ctrl_model.sv
// Purpose: controller at the far side of the state link
// Assumes: link comes up one edge after the bench asks for it
// Notes:   counts every transmitted copy and keeps the last one
`timescale 1ns/1ps
module oes_ctrl_model (
    // clock and control
    input  wire logic               i_clk,
    input  wire logic               i_connect,
    // traffic from the device
    input  wire logic               i_send,
    input  wire oes_pkg::oes_elem_t i_copy,
    // link state and received values
    output logic                    o_link_up,
    output int                      o_sends,
    output oes_pkg::oes_elem_t      o_last
);
    // start disconnected with nothing received
    initial begin
        o_link_up = 1'b0;
        o_sends   = 0;
        o_last    = '0;
    end
    // receive each copy only while the link stands
    always @(posedge i_clk) begin
        o_link_up <= i_connect;
        if (i_send && o_link_up) begin
            o_sends <= o_sends + 1;
            o_last  <= i_copy;
        end
    end
endmodule : oes_ctrl_model

// file: oes_top_test.sv
// Purpose: self-checking bench for oes_top
// Assumes: shortened debounce, filter and divider counts
// Notes:   integer model of element state compared through chk_sync and the key and net reads
`timescale 1ns/1ps
module oes_top_test;
    logic clk, rst_n, btn, kcw, kccw, wf, wb, rd, wr, lamp, lock, send, conn, link;
    logic               [3:0]  adr;
    logic               [31:0] wd, rdata, a0;
    logic               [1:0]  c;
    oes_pkg::oes_elem_t        stale, copy, last;
    int                        err_total, checks_done, sends, e_sends, e_net, e_btn, nf, nb;
    int                        edges;
    int                        lo[4] = '{0, 15, 3, 0};
    int                        hi[4] = '{0, 17, 5, 0};
    logic               [1:0]  e_key;
    integer                    seed = 32'h33c49861;

    oes_top #(.DEBOUNCE_CYC(4), .WHEEL_FILT_CYC(2), .ALIVE_CYC(8), .SLOW_HALF_CYC(16),
        .RAPID_HALF_CYC(4)) oes_top_inst (.I_CORE_CLK(clk), .I_ARST_N(rst_n),
        .I_BUTTON_PRESSED(btn), .I_KEY_CW(kcw), .I_KEY_CCW(kccw), .I_WHEEL_FWD(wf),
        .I_WHEEL_BWD(wb), .I_LINK_UP(link), .I_STALE_VALUE(stale), .I_ADDR(adr),
        .I_WDATA(wd), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_LAMP(lamp),
        .O_PROTECT_LOCK(lock), .O_CTRL_COPY(copy), .O_CTRL_SEND(send));
    oes_ctrl_model oes_ctrl_model_inst (.i_clk(clk), .i_connect(conn), .i_send(send),
        .i_copy(copy), .o_link_up(link), .o_sends(sends), .o_last(last));

    // free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk) {adr, wd, wr} <= {a, d, 1'b1};
        @(posedge clk) wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk) {adr, rd} <= {a, 1'b1};
        @(posedge clk) rd <= 1'b0;
        @(negedge clk) d = rdata;
    endtask : rd_reg
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd_reg(a, d);
        check(d, exp);
    endtask : rd_chk
    // transmitted count and last copy against the model
    task automatic chk_sync;
        check(sends, e_sends);
        check({13'h0, last}, {13'h0, e_net[15:0], e_key, e_btn[0]});
    endtask : chk_sync
    task automatic settle;
        repeat (20) @(posedge clk);
    endtask : settle
    task automatic finish_test;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test

    // watchdog against a hung run
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        finish_test;
    end
    // main sequence
    initial begin
        {rst_n, btn, kcw, kccw, wf, wb, rd, wr, conn, adr, wd, stale} = '0;
        {e_sends, e_net, e_key, e_btn} = {32'h0, 32'h0, 2'h0, 32'h1};
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(oes_pkg::ADR_CFG, {29'h0, oes_pkg::CFG_RESET});
        rd_chk(oes_pkg::ADR_STATUS, 32'h1);
        rd_chk(oes_pkg::ADR_FWD_CNT, 32'h0);
        rd_chk(oes_pkg::ADR_BWD_CNT, 32'h0);
        @(posedge clk) stale <= 19'($random(seed));
        conn <= 1'b1;
        settle;
        rd_chk(oes_pkg::ADR_CTRL_COPY, {13'h0, stale});
        check(sends, 0);
        a0 = {16'h0, 16'($random(seed)) | 16'h1};
        wr_reg(oes_pkg::ADR_TRIG, a0);
        settle;
        e_sends++;
        chk_sync;
        wr_reg(oes_pkg::ADR_TRIG, a0);
        settle;
        chk_sync;
        @(posedge clk) btn <= 1'b1;
        settle;
        {e_btn, e_sends} = {32'h0, e_sends + 1};
        rd_chk(oes_pkg::ADR_STATUS, 32'h0);
        chk_sync;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk) {kccw, kcw} <= 2'(k);
            c = (k == 1) ? oes_pkg::KEY_CW : (k == 2) ? oes_pkg::KEY_CCW : oes_pkg::KEY_CENTRE;
            e_sends += (c != e_key);
            e_key = c;
            settle;
            rd_chk(oes_pkg::ADR_KEY, {30'h0, e_key});
            check(lock, e_key != 2'h0);
            chk_sync;
        end
        nf = 250 + ($random(seed) & 15);
        nb = $random(seed) & 7;
        for (int i = 0; i < nf + nb; i++) begin
            @(posedge clk) {wf, wb} <= (i < nf) ? 2'b10 : 2'b01;
            repeat (6) @(posedge clk);
            {wf, wb} <= 2'b00;
            repeat (6) @(posedge clk);
            if (i == 127) rd_chk(oes_pkg::ADR_FWD_CNT, 32'h80);
        end
        settle;
        {e_net, e_sends} = {(nf - nb) & 32'hffff, e_sends + nf + nb};
        rd_reg(oes_pkg::ADR_NET, a0);
        check(a0 & 32'hffff, e_net);
        rd_chk(oes_pkg::ADR_FWD_CNT, nf & 255);
        rd_chk(oes_pkg::ADR_BWD_CNT, nb);
        chk_sync;
        e_net = (nf - nb) & 32'hff;
        wr_reg(oes_pkg::ADR_CFG, 32'h1);
        rd_chk(oes_pkg::ADR_NET, e_net | (e_net >> 7) * 32'hff00);
        for (int l = 0; l < 4; l++) begin
            wr_reg(oes_pkg::ADR_LAMP, 32'(l));
            rd_chk(oes_pkg::ADR_LAMP, 32'(l));
            edges = 0;
            repeat (64) begin
                a0[0] = lamp;
                @(posedge clk) #1;
                edges += (lamp !== a0[0]);
            end
            check(edges >= lo[l] && edges <= hi[l], 32'h1);
            if (l == 0 || l == 3)
                check(lamp, l == 3);
        end
        for (int j = 0; j < 2; j++) begin
            rd_reg(oes_pkg::ADR_ALIVE, a0);
            repeat (6) @(posedge clk);
            rd_chk(oes_pkg::ADR_ALIVE, {31'h0, ~a0[0]});
        end
        @(posedge clk) {kccw, kcw} <= 2'b01;
        wr_reg(oes_pkg::ADR_CFG, 32'h6);
        settle;
        rd_chk(oes_pkg::ADR_KEY, 32'h1);
        rd_chk(4'hf, 32'h0);
        finish_test;
    end
endmodule : oes_top_test
